//--- hdl/iopd_defs.svh
`ifndef IOPD_DEFS_SVH
`define IOPD_DEFS_SVH

// register offsets on the serial link
`define IOPD_OFS_PWR 8'h00
`define IOPD_OFS_WAKE 8'h01
`define IOPD_OFS_XLO 8'h02
`define IOPD_OFS_DP 8'h03
`define IOPD_OFS_CC 8'h04
`define IOPD_OFS_STD 8'h05
`define IOPD_OFS_PIX 8'h06
`define IOPD_OFS_MUTE 8'h0A
`define IOPD_OFS_LLC 8'h0C

// storage slot of each register
`define IOPD_IX_PWR 4'h0
`define IOPD_IX_WAKE 4'h1
`define IOPD_IX_XLO 4'h2
`define IOPD_IX_DP 4'h3
`define IOPD_IX_CC 4'h4
`define IOPD_IX_STD 4'h5
`define IOPD_IX_PIX 4'h6
`define IOPD_IX_MUTE 4'h7
`define IOPD_IX_LLC 4'h8
`define IOPD_IX_NONE 4'hF

// reset values
`define IOPD_RST_PWR 8'h33
`define IOPD_RST_WAKE 8'hB6
`define IOPD_RST_XLO 8'h00
`define IOPD_RST_DP 8'h06
`define IOPD_RST_CC 8'h02
`define IOPD_RST_STD 8'h40
`define IOPD_RST_PIX 8'h11
`define IOPD_RST_MUTE 8'h00
`define IOPD_RST_LLC 8'h00

// field positions
`define IOPD_B_RX_EN 6
`define IOPD_B_RX_PD 5
`define IOPD_B_XTAL_PD 2
`define IOPD_B_FULL 1
`define IOPD_B_DEEP 0
`define IOPD_B_WAKE_HI 7
`define IOPD_B_WAKE_LO 6
`define IOPD_B_TCI 7
`define IOPD_B_RATE_HI 6
`define IOPD_B_RATE_LO 4
`define IOPD_B_CLIP 3
`define IOPD_B_BLANK 2
`define IOPD_B_FREN 1
`define IOPD_B_SKIP 0
`define IOPD_B_FORCE 7
`define IOPD_B_REPL 5
`define IOPD_B_ALT 3
`define IOPD_B_SATINV 2
`define IOPD_B_RGB 1
`define IOPD_B_REV 6
`define IOPD_B_DDR 5
`define IOPD_B_SPLIT 4
`define IOPD_B_KEEP 0
`define IOPD_B_MUTE 6
`define IOPD_B_DLL_EN 7
`define IOPD_B_DLL_DBL 6
`define IOPD_B_DLL_MUX 5
`define IOPD_B_PHASE_HI 4
`define IOPD_RATE_MAX 3'h4

`endif

//--- hdl/iopd_pkg.sv
package iopd_pkg;

    // serial link slave phases
    typedef enum logic [3:0] {
        IOPD_IDLE, IOPD_ADDR, IOPD_AACK, IOPD_SUB, IOPD_SACK,
        IOPD_WDATA, IOPD_WACK, IOPD_RDATA, IOPD_RACK
    } iopd_state_e_t;

    // whole state of the block
    typedef struct packed {
        iopd_state_e_t st;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic rw, nack, oe, sda_o, scl_q, sda_q, ever_conn;
        logic [8:0][7:0] regs;
        logic rx_en, rx_pd, xtal_pd, proc_pd, irq_gen_pd, cec_wake;
        logic [13:0] xtal_freq;
        logic tc_ins, clip, blank, fr_en, fr_force, skip, repl, csc_alt, sat_en, rgb;
        logic [2:0] rate;
        logic [5:0] csc_cfg;
        logic fr_active, fr_buffered, std_gen;
        logic [7:0] std_code;
        logic [7:0] pix_data;
        logic ddr, split, keep, vmute, dll_en, dll_dbl, dll_mux;
        logic [4:0] dll_phase;
    } iopd_state_t;

endpackage

//--- hdl/iopd_top.sv
`include "iopd_defs.svh"

module iopd_top #(
    parameter logic [6:0] DEV_ADDR = 7'h20 // arbitrary link address
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // serial host link, open drain data
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // video side status and data
    input wire logic input_present,
    input wire logic param_buffer_disable,
    input wire logic [3:0] input_colorspace_select,
    input wire logic [7:0] pixel_in,
    // power controls
    output logic receiver_enable,
    output logic receiver_power_down,
    output logic crystal_amp_power_down,
    output logic processor_power_down,
    output logic irq_gen_power_down,
    output logic cec_wake_enable,
    output logic [13:0] crystal_freq_value,
    // processor controls
    output logic timing_code_insert,
    output logic [2:0] field_rate_select,
    output logic limited_range_clip,
    output logic blanking_zero_enable,
    output logic freewheel_enable,
    output logic freewheel_force,
    output logic processor_skip,
    output logic timing_code_replicate,
    output logic alt_convert_active,
    output logic saturator_enable,
    output logic rgb_output_select,
    output logic [5:0] csc_config,
    output logic freerun_active,
    output logic freerun_buffered,
    output logic std_param_generate,
    output logic [7:0] video_standard_code,
    // pixel input port
    output logic [7:0] pixel_data,
    output logic input_double_rate,
    output logic input_timing_code_split,
    output logic input_timing_code_keep,
    // mute and output clock loop
    output logic video_mute,
    output logic dll_enable,
    output logic dll_double,
    output logic dll_mux,
    output logic [4:0] dll_phase
);
    import iopd_pkg::*;

    iopd_state_t q;
    iopd_state_t d;
    logic scl_rise, scl_fall, start_cond, stop_cond, sleep;
    logic [3:0] wr_ix;
    logic [7:0] rd_data;

    // offset to storage slot
    function automatic logic [3:0] ofs2idx(input logic [7:0] ofs);
        if (ofs == `IOPD_OFS_PWR) return `IOPD_IX_PWR;
        else if (ofs == `IOPD_OFS_WAKE) return `IOPD_IX_WAKE;
        else if (ofs == `IOPD_OFS_XLO) return `IOPD_IX_XLO;
        else if (ofs == `IOPD_OFS_DP) return `IOPD_IX_DP;
        else if (ofs == `IOPD_OFS_CC) return `IOPD_IX_CC;
        else if (ofs == `IOPD_OFS_STD) return `IOPD_IX_STD;
        else if (ofs == `IOPD_OFS_PIX) return `IOPD_IX_PIX;
        else if (ofs == `IOPD_OFS_MUTE) return `IOPD_IX_MUTE;
        else if (ofs == `IOPD_OFS_LLC) return `IOPD_IX_LLC;
        else return `IOPD_IX_NONE;
    endfunction

    // link edges and bus conditions
    assign scl_rise = scl_in & ~q.scl_q;
    assign scl_fall = ~scl_in & q.scl_q;
    assign start_cond = scl_in & q.scl_q & q.sda_q & ~sda_in;
    assign stop_cond = scl_in & q.scl_q & ~q.sda_q & sda_in;
    assign wr_ix = ofs2idx(q.ptr);
    assign rd_data = (wr_ix == `IOPD_IX_NONE) ? 8'h00 : q.regs[wr_ix]; // unmapped reads zero
    assign sleep = q.regs[`IOPD_IX_PWR][`IOPD_B_FULL] | q.regs[`IOPD_IX_PWR][`IOPD_B_DEEP];

    // next state
    always_comb begin
        d = q;
        d.scl_q = scl_in;
        d.sda_q = sda_in;
        d.sda_o = 1'b0;
        // serial slave: start and stop win over bit traffic
        if (start_cond) begin
            d.st = IOPD_ADDR;
            d.cnt = 4'h0;
            d.oe = 1'b0;
        end else if (stop_cond) begin
            d.st = IOPD_IDLE;
            d.oe = 1'b0;
        end else if (scl_rise) begin
            case (q.st)
                IOPD_ADDR, IOPD_SUB, IOPD_WDATA: begin
                    d.shreg = {q.shreg[6:0], sda_in};
                    d.cnt = q.cnt + 4'h1;
                end
                IOPD_RACK: d.nack = sda_in;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (q.st)
                IOPD_ADDR: if (q.cnt == 4'h8) begin
                    if (q.shreg[7:1] == DEV_ADDR) begin
                        d.oe = 1'b1;
                        d.rw = q.shreg[0];
                        d.st = IOPD_AACK;
                    end else begin
                        d.st = IOPD_IDLE;
                    end
                end
                IOPD_AACK: begin
                    d.cnt = 4'h0;
                    if (q.rw) begin
                        d.shreg = rd_data;
                        d.oe = ~rd_data[7];
                        d.st = IOPD_RDATA;
                    end else begin
                        d.oe = 1'b0;
                        d.st = IOPD_SUB;
                    end
                end
                IOPD_SUB: if (q.cnt == 4'h8) begin
                    d.ptr = q.shreg;
                    d.oe = 1'b1;
                    d.st = IOPD_SACK;
                end
                IOPD_SACK, IOPD_WACK: begin
                    d.oe = 1'b0;
                    d.cnt = 4'h0;
                    d.st = IOPD_WDATA;
                end
                IOPD_WDATA: if (q.cnt == 4'h8) begin
                    if (wr_ix != `IOPD_IX_NONE) begin
                        d.regs[wr_ix] = q.shreg;
                    end
                    d.ptr = q.ptr + 8'h01;
                    d.oe = 1'b1;
                    d.st = IOPD_WACK;
                end
                IOPD_RDATA: begin
                    if (q.cnt == 4'h7) begin
                        d.oe = 1'b0;
                        d.ptr = q.ptr + 8'h01;
                        d.st = IOPD_RACK;
                    end else begin
                        d.shreg = {q.shreg[6:0], 1'b0};
                        d.oe = ~q.shreg[6];
                        d.cnt = q.cnt + 4'h1;
                    end
                end
                IOPD_RACK: begin
                    if (q.nack) begin
                        d.oe = 1'b0;
                        d.st = IOPD_IDLE;
                    end else begin
                        d.shreg = rd_data;
                        d.oe = ~rd_data[7];
                        d.cnt = 4'h0;
                        d.st = IOPD_RDATA;
                    end
                end
                default: ;
            endcase
        end
        // power: either sleep mode overrides the individual bits
        d.rx_en = q.regs[`IOPD_IX_PWR][`IOPD_B_RX_EN] & ~sleep;
        d.rx_pd = q.regs[`IOPD_IX_PWR][`IOPD_B_RX_PD] | sleep;
        d.xtal_pd = q.regs[`IOPD_IX_PWR][`IOPD_B_XTAL_PD] | sleep;
        d.proc_pd = sleep;
        d.irq_gen_pd = q.regs[`IOPD_IX_PWR][`IOPD_B_DEEP] & ~q.regs[`IOPD_IX_PWR][`IOPD_B_FULL];
        // wake stays armed while either bit still asks for it
        d.cec_wake = q.regs[`IOPD_IX_WAKE][`IOPD_B_WAKE_HI]
                   | ~q.regs[`IOPD_IX_WAKE][`IOPD_B_WAKE_LO];
        d.xtal_freq = {q.regs[`IOPD_IX_WAKE][5:0], q.regs[`IOPD_IX_XLO]};
        // processor datapath controls
        d.tc_ins = q.regs[`IOPD_IX_DP][`IOPD_B_TCI];
        if (q.regs[`IOPD_IX_DP][`IOPD_B_RATE_HI:`IOPD_B_RATE_LO] <= `IOPD_RATE_MAX) begin
            d.rate = q.regs[`IOPD_IX_DP][`IOPD_B_RATE_HI:`IOPD_B_RATE_LO];
        end
        d.clip = q.regs[`IOPD_IX_DP][`IOPD_B_CLIP];
        d.blank = q.regs[`IOPD_IX_DP][`IOPD_B_BLANK];
        d.fr_en = q.regs[`IOPD_IX_DP][`IOPD_B_FREN];
        d.fr_force = q.regs[`IOPD_IX_CC][`IOPD_B_FORCE];
        d.skip = q.regs[`IOPD_IX_DP][`IOPD_B_SKIP];
        d.repl = q.regs[`IOPD_IX_CC][`IOPD_B_REPL];
        d.csc_alt = q.regs[`IOPD_IX_CC][`IOPD_B_ALT] & ~q.regs[`IOPD_IX_CC][`IOPD_B_RGB];
        d.sat_en = q.regs[`IOPD_IX_DP][`IOPD_B_CLIP] ^ q.regs[`IOPD_IX_CC][`IOPD_B_SATINV];
        d.rgb = q.regs[`IOPD_IX_CC][`IOPD_B_RGB];
        d.csc_cfg = {input_colorspace_select, q.regs[`IOPD_IX_CC][`IOPD_B_RGB], d.csc_alt};
        // free-run: forced, or automatic on loss of input
        d.ever_conn = q.ever_conn | input_present;
        d.fr_active = q.fr_en & (q.fr_force | ~input_present) & ~q.skip;
        d.fr_buffered = d.fr_active & q.ever_conn & ~param_buffer_disable;
        d.std_gen = d.fr_active & ~d.fr_buffered;
        d.std_code = q.regs[`IOPD_IX_STD];
        // pixel input port
        d.pix_data = q.regs[`IOPD_IX_PIX][`IOPD_B_REV] ?
            {pixel_in[0], pixel_in[1], pixel_in[2], pixel_in[3], pixel_in[4], pixel_in[5], pixel_in[6], pixel_in[7]}
            : pixel_in;
        d.ddr = q.regs[`IOPD_IX_PIX][`IOPD_B_DDR];
        d.split = q.regs[`IOPD_IX_PIX][`IOPD_B_SPLIT];
        d.keep = q.regs[`IOPD_IX_PIX][`IOPD_B_KEEP];
        // mute and clock loop
        d.vmute = q.regs[`IOPD_IX_MUTE][`IOPD_B_MUTE];
        d.dll_en = q.regs[`IOPD_IX_LLC][`IOPD_B_DLL_EN];
        d.dll_dbl = q.regs[`IOPD_IX_LLC][`IOPD_B_DLL_DBL];
        d.dll_mux = q.regs[`IOPD_IX_LLC][`IOPD_B_DLL_MUX];
        d.dll_phase = q.regs[`IOPD_IX_LLC][`IOPD_B_PHASE_HI:0];
    end

    // state register with synchronous reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
            q.scl_q <= 1'b1;
            q.sda_q <= 1'b1;
            q.regs <= {`IOPD_RST_LLC, `IOPD_RST_MUTE, `IOPD_RST_PIX, `IOPD_RST_STD, `IOPD_RST_CC,
                       `IOPD_RST_DP, `IOPD_RST_XLO, `IOPD_RST_WAKE, `IOPD_RST_PWR};
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign sda_out = q.sda_o;
    assign sda_oe = q.oe;
    assign receiver_enable = q.rx_en;
    assign receiver_power_down = q.rx_pd;
    assign crystal_amp_power_down = q.xtal_pd;
    assign processor_power_down = q.proc_pd;
    assign irq_gen_power_down = q.irq_gen_pd;
    assign cec_wake_enable = q.cec_wake;
    assign crystal_freq_value = q.xtal_freq;
    assign timing_code_insert = q.tc_ins;
    assign field_rate_select = q.rate;
    assign limited_range_clip = q.clip;
    assign blanking_zero_enable = q.blank;
    assign freewheel_enable = q.fr_en;
    assign freewheel_force = q.fr_force;
    assign processor_skip = q.skip;
    assign timing_code_replicate = q.repl;
    assign alt_convert_active = q.csc_alt;
    assign saturator_enable = q.sat_en;
    assign rgb_output_select = q.rgb;
    assign csc_config = q.csc_cfg;
    assign freerun_active = q.fr_active;
    assign freerun_buffered = q.fr_buffered;
    assign std_param_generate = q.std_gen;
    assign video_standard_code = q.std_code;
    assign pixel_data = q.pix_data;
    assign input_double_rate = q.ddr;
    assign input_timing_code_split = q.split;
    assign input_timing_code_keep = q.keep;
    assign video_mute = q.vmute;
    assign dll_enable = q.dll_en;
    assign dll_double = q.dll_dbl;
    assign dll_mux = q.dll_mux;
    assign dll_phase = q.dll_phase;

    // checks on the block's own behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    rx_power_a: assert property (q.regs[`IOPD_IX_PWR][`IOPD_B_RX_PD] |=> receiver_power_down)
        else $error("receiver not powered down");
    rx_enable_a: assert property (receiver_enable |->
        $past(q.regs[`IOPD_IX_PWR][`IOPD_B_RX_EN]) && !$past(sleep))
        else $error("receiver enabled without cause");
    xtal_power_a: assert property (q.regs[`IOPD_IX_PWR][`IOPD_B_XTAL_PD] |=> crystal_amp_power_down)
        else $error("crystal amplifier left on");
    full_sleep_a: assert property (q.regs[`IOPD_IX_PWR][`IOPD_B_FULL] |=>
        receiver_power_down && crystal_amp_power_down && processor_power_down && !irq_gen_power_down)
        else $error("full sleep power state wrong");
    deep_sleep_a: assert property (q.regs[`IOPD_IX_PWR][1:0] == 2'b01 |=>
        processor_power_down && irq_gen_power_down && !receiver_enable)
        else $error("deep sleep power state wrong");
    wake_off_a: assert property (q.regs[`IOPD_IX_WAKE][7:6] == 2'b01 |=> !cec_wake_enable)
        else $error("wake armed in normal mode");
    wake_on_a: assert property (q.regs[`IOPD_IX_WAKE][7:6] == 2'b10 |=> cec_wake_enable)
        else $error("wake not armed by default code");
    xtal_value_a: assert property (1'b1 |=>
        crystal_freq_value == {$past(q.regs[`IOPD_IX_WAKE][5:0]), $past(q.regs[`IOPD_IX_XLO])})
        else $error("crystal value misassembled");
    rate_hold_a: assert property (q.regs[`IOPD_IX_DP][6:4] > 3'h4 |=> $stable(field_rate_select))
        else $error("reserved rate code taken");
    csc_alt_a: assert property (q.regs[`IOPD_IX_CC][`IOPD_B_RGB] |=> !alt_convert_active)
        else $error("conversion active with RGB output");
    sat_follow_a: assert property (1'b1 |=> saturator_enable ==
        ($past(q.regs[`IOPD_IX_DP][`IOPD_B_CLIP]) ^ $past(q.regs[`IOPD_IX_CC][`IOPD_B_SATINV])))
        else $error("saturator decision wrong");
    std_gen_a: assert property (std_param_generate |-> freerun_active && !freerun_buffered)
        else $error("standard drives buffered free-run");
    buffered_a: assert property (freerun_buffered |-> $past(q.ever_conn) && !$past(param_buffer_disable))
        else $error("buffered free-run without history");
    pix_rev_a: assert property (q.regs[`IOPD_IX_PIX][`IOPD_B_REV] |=>
        pixel_data[0] == $past(pixel_in[7]) && pixel_data[7] == $past(pixel_in[0]))
        else $error("pixel bus not reversed");
    addr_ack_a: assert property (q.st == IOPD_ADDR && scl_fall && q.cnt == 4'h8 && q.shreg[7:1] == DEV_ADDR
        |=> sda_oe ##1 sda_oe[*1])
        else $error("address not acknowledged");
    write_ack_a: assert property (q.st == IOPD_WDATA && scl_fall && q.cnt == 4'h8
        |=> sda_oe)
        else $error("data byte not acknowledged");
    stop_idle_a: assert property (stop_cond
        |=> q.st == IOPD_IDLE && !sda_oe)
        else $error("stop did not release the link");

    // control outputs follow their register bits one cycle later, the field rate only for codes up to 4
    tc_insert_a: assert property (1'b1 |=>
        timing_code_insert == $past(q.regs[`IOPD_IX_DP][`IOPD_B_TCI]))
        else $error("insert control wrong");
    clip_follow_a: assert property (1'b1 |=>
        limited_range_clip == $past(q.regs[`IOPD_IX_DP][`IOPD_B_CLIP]))
        else $error("clip control wrong");
    blank_follow_a: assert property (1'b1 |=>
        blanking_zero_enable == $past(q.regs[`IOPD_IX_DP][`IOPD_B_BLANK]))
        else $error("blanking control wrong");
    repl_follow_a: assert property (1'b1 |=>
        timing_code_replicate == $past(q.regs[`IOPD_IX_CC][`IOPD_B_REPL]))
        else $error("replicate control wrong");
    rgb_follow_a: assert property (1'b1 |=>
        rgb_output_select == $past(q.regs[`IOPD_IX_CC][`IOPD_B_RGB]))
        else $error("output space control wrong");
    std_code_a: assert property (1'b1 |=>
        video_standard_code == $past(q.regs[`IOPD_IX_STD]))
        else $error("standard code wrong");
    ddr_follow_a: assert property (1'b1 |=>
        input_double_rate == $past(q.regs[`IOPD_IX_PIX][`IOPD_B_DDR]))
        else $error("input rate control wrong");
    split_follow_a: assert property (1'b1 |=>
        input_timing_code_split == $past(q.regs[`IOPD_IX_PIX][`IOPD_B_SPLIT]))
        else $error("split control wrong");
    rate_take_a: assert property (q.regs[`IOPD_IX_DP][6:4] <= 3'h4 |=>
        field_rate_select == $past(q.regs[`IOPD_IX_DP][6:4]))
        else $error("valid rate code not taken");

    // free-run decisions
    force_run_a: assert property (freewheel_enable && freewheel_force && !processor_skip |=>
        freerun_active)
        else $error("forced free-run missing");
    skip_block_a: assert property (processor_skip |=>
        !freerun_active)
        else $error("free-run while bypassed");
    unbuffered_a: assert property (freerun_active && !freerun_buffered |->
        !$past(q.ever_conn) || $past(param_buffer_disable))
        else $error("buffered free-run skipped");

    write_seen_c: cover property (q.st == IOPD_WDATA && scl_fall && q.cnt == 4'h8);
    read_seen_c: cover property (q.st == IOPD_RACK && scl_fall && !q.nack);
    buffered_c: cover property (freerun_buffered);
    full_sleep_c: cover property (processor_power_down && !irq_gen_power_down);
    deep_sleep_c: cover property (irq_gen_power_down);

endmodule

//--- verification/iopd_host.sv
module iopd_host (
    // clock
    input wire logic core_clk,
    // serial link, open drain data with pull-up
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 100ps;
    // both lines released at time zero
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // wait n edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // data set in low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        tick(4);
        scl = 1'b1;
        tick(2);
        r = sda_line;
        tick(2);
        scl = 1'b0;
    endtask
    // start or repeated start
    task automatic start_c();
        sda_low = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic stop_c();
        sda_low = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(4);
    endtask
    // byte out msb first, then the device acknowledge
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // byte in, host nack on the last one
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
    // one or two data bytes from a sub address, upper byte first
    task automatic wr(input logic [6:0] dev, input logic [7:0] sub, input logic [15:0] d, input int n,
                      output logic ok);
        logic a;
        start_c();
        send({dev, 1'b0}, ok);
        send(sub, a);
        ok &= a;
        if (n == 2) begin
            send(d[15:8], a);
            ok &= a;
        end
        send(d[7:0], a);
        ok &= a;
        stop_c();
    endtask
    // pointer set by a write, then repeated start read
    task automatic rd(input logic [6:0] dev, input logic [7:0] sub, output logic [7:0] d, output logic ok);
        logic a;
        start_c();
        send({dev, 1'b0}, ok);
        send(sub, a);
        ok &= a;
        start_c();
        send({dev, 1'b1}, a);
        ok &= a;
        recv(1'b1, d);
        stop_c();
    endtask
endmodule

//--- verification/iopd_top_tb_top.sv
module iopd_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] dev_addr = 7'h20;
    logic core_clk, rst, scl_in, sda_in, sda_low, input_present, param_buffer_disable;
    logic [3:0] input_colorspace_select;
    logic [7:0] pixel_in, pixel_data, video_standard_code;
    logic sda_out, sda_oe, receiver_enable, receiver_power_down, crystal_amp_power_down;
    logic processor_power_down, irq_gen_power_down, cec_wake_enable, timing_code_insert;
    logic limited_range_clip, blanking_zero_enable, freewheel_enable, freewheel_force, processor_skip;
    logic timing_code_replicate, alt_convert_active, saturator_enable, rgb_output_select;
    logic freerun_active, freerun_buffered, std_param_generate, input_double_rate;
    logic input_timing_code_split, input_timing_code_keep, video_mute, dll_enable, dll_double, dll_mux;
    logic [13:0] crystal_freq_value;
    logic [2:0] field_rate_select;
    logic [5:0] csc_config;
    logic [4:0] dll_phase;
    int bad_count = 0;
    int comparisons = 0;
    logic ok;
    logic [7:0] ofs [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0A, 8'h0C, 8'h07};
    logic [7:0] rv [10] = '{8'h33, 8'hB6, 8'h00, 8'h06, 8'h02, 8'h40, 8'h11, 8'h00, 8'h00, 8'h00};
    logic [7:0] pv [4] = '{8'h40, 8'h24, 8'h02, 8'h01};
    logic [4:0] pe [4] = '{5'h10, 5'h0C, 5'h0E, 5'h0F};

    // wire level: pull-up unless someone pulls low
    assign sda_in = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);

    iopd_top #(.DEV_ADDR(dev_addr)) i_dut (.*);
    iopd_host i_host (.core_clk(core_clk), .sda_line(sda_in), .scl(scl_in), .sda_low(sda_low));

    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic w(input logic [7:0] sub, input logic [15:0] d, input int n);
        logic a;
        i_host.wr(dev_addr, sub, d, n, a);
        chk("ack", 1'b1, a);
    endtask
    task automatic r(input logic [7:0] sub, input logic [7:0] exp);
        logic a;
        logic [7:0] d;
        i_host.rd(dev_addr, sub, d, a);
        chk("ack", 1'b1, a);
        chk("rdata", exp, d);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // cut a hang short
    initial begin
        #150000;
        bad_count++;
        $display("watchdog expired");
        print_verdict();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        input_present = 1'b0;
        param_buffer_disable = 1'b0;
        input_colorspace_select = 4'h3;
        pixel_in = 8'h83;
        i_host.tick(6);
        rst = 1'b0;
        i_host.tick(4);
        // reset state, never connected input
        chk("pwr", 5'h0E, {receiver_enable, receiver_power_down, crystal_amp_power_down,
            processor_power_down, irq_gen_power_down});
        chk("wake", 1'b1, cec_wake_enable);
        chk("xtal", 14'h3600, crystal_freq_value);
        chk("std", 8'h40, video_standard_code);
        chk("fr", 3'h5, {freerun_active, freerun_buffered, std_param_generate});
        for (int i = 0; i < 10; i++) r(ofs[i], rv[i]);
        $display("test reset done");
        // power modes
        for (int i = 0; i < 4; i++) begin
            w(8'h00, pv[i], 1);
            chk("pwr", pe[i], {receiver_enable, receiver_power_down, crystal_amp_power_down,
                processor_power_down, irq_gen_power_down});
        end
        $display("test power done");
        // wake bits for normal operation and crystal value across two registers
        w(8'h01, 16'h45A3, 2);
        chk("wake", 1'b0, cec_wake_enable);
        chk("xtal", 14'h05A3, crystal_freq_value);
        w(8'h01, 16'h00C0, 1);
        chk("wake", 1'b1, cec_wake_enable);
        chk("xtal", 14'h00A3, crystal_freq_value);
        r(8'h02, 8'hA3);
        $display("test wake done");
        // every field rate code, then a reserved one
        input_present = 1'b1;
        for (int i = 0; i < 5; i++) begin
            w(8'h03, {1'b1, i[2:0], 4'hE}, 1);
            chk("rate", i[2:0], field_rate_select);
        end
        chk("dp", 5'h1E, {timing_code_insert, limited_range_clip, blanking_zero_enable,
            freewheel_enable, processor_skip});
        w(8'h03, 8'hDE, 1);
        chk("rate", 3'h4, field_rate_select);
        $display("test datapath done");
        // colour controls, forced free-run after a connection
        w(8'h04, 8'hA8, 1);
        chk("cc", 5'h1E, {freewheel_force, timing_code_replicate, alt_convert_active,
            saturator_enable, rgb_output_select});
        chk("csc", 6'h0D, csc_config);
        chk("fr", 3'h6, {freerun_active, freerun_buffered, std_param_generate});
        w(8'h04, 8'h0E, 1);
        chk("cc", 5'h01, {freewheel_force, timing_code_replicate, alt_convert_active,
            saturator_enable, rgb_output_select});
        chk("csc", 6'h0E, csc_config);
        chk("fr", 1'b0, freerun_active);
        // input loss, buffer disable, bypass
        input_present = 1'b0;
        i_host.tick(3);
        chk("fr", 3'h6, {freerun_active, freerun_buffered, std_param_generate});
        param_buffer_disable = 1'b1;
        i_host.tick(3);
        chk("fr", 3'h5, {freerun_active, freerun_buffered, std_param_generate});
        w(8'h03, 8'h8F, 1);
        chk("fr", 1'b0, freerun_active);
        $display("test freerun done");
        // standard codes, pixel port, mute, clock loop
        w(8'h05, 16'h005E, 1);
        chk("std", 8'h5E, video_standard_code);
        w(8'h05, 16'h0096, 1);
        chk("std", 8'h96, video_standard_code);
        w(8'h06, 8'h71, 1);
        chk("pix", 8'hC1, pixel_data);
        chk("pcfg", 3'h7, {input_double_rate, input_timing_code_split, input_timing_code_keep});
        w(8'h06, 8'h01, 1);
        chk("pix", 8'h83, pixel_data);
        chk("pcfg", 3'h1, {input_double_rate, input_timing_code_split, input_timing_code_keep});
        w(8'h0A, 8'h40, 1);
        w(8'h0C, 8'hB5, 1);
        chk("misc", 9'h1B5, {video_mute, dll_enable, dll_double, dll_mux, dll_phase});
        $display("test ports done");
        // unmapped place and foreign address
        w(8'h07, 8'h55, 1);
        r(8'h07, 8'h00);
        i_host.wr(7'h21, 8'h0C, 16'h0000, 1, ok);
        chk("nack", 1'b0, ok);
        r(8'h0C, 8'hB5);
        $display("test refusal done");
        print_verdict();
    end
endmodule
